/* dmadm_pkg.sv */
package dmadm_pkg;

    // Staging buffer and byte counter.
    localparam int BUF_BYTES = 8192;
    localparam int CNT_W = 32;
    localparam int BLK_W = 13;
    localparam logic [BLK_W-1:0] BLK_MIN = 13'h0020;

    // Clock rate and back-off time base.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BACKOFF_UNIT_PS = 1000000;
    localparam int US_CYCLES = (BACKOFF_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BACKOFF_MAX_US = 64;
    localparam int BO_TMR_W = 24;

    // Register offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SRC = 8'h04;
    localparam logic [7:0] REG_DST = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_THROT = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_REMAIN = 8'h18;

    // Channel control fields.
    localparam int CTL_GO = 0;
    localparam int CTL_PAT_EN = 1;
    localparam int CTL_SRC_VME = 2;
    localparam int CTL_DST_VME = 3;
    localparam int CTL_PAT_W32 = 4;
    localparam int CTL_PAT_INC = 5;
    localparam int CTL_PBS_LSB = 8;
    localparam int CTL_VBS_LSB = 12;
    localparam int BS_W = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Throttle fields, back-off in microseconds.
    localparam int THR_PBO_LSB = 0;
    localparam int THR_VBO_LSB = 8;
    localparam int BO_W = 7;
    localparam logic [31:0] THROT_RST = 32'h0000_0000;

    // Status fields.
    localparam int STA_BUSY = 0;
    localparam int STA_FILL = 1;
    localparam int STA_LVL_LSB = 16;

    typedef enum logic [3:0] {
        DMADM_RD_IDLE = 4'b0001,
        DMADM_RD_REQ = 4'b0010,
        DMADM_RD_DATA = 4'b0100,
        DMADM_RD_WAIT = 4'b1000
    } dmadm_rd_state_t;

    typedef enum logic [3:0] {
        DMADM_WR_IDLE = 4'b0001,
        DMADM_WR_REQ = 4'b0010,
        DMADM_WR_DATA = 4'b0100,
        DMADM_WR_WAIT = 4'b1000
    } dmadm_wr_state_t;

endpackage

/* dmadm_channel.sv */
// Function
// - Program setup registers first; a go bit write launches the transfer.
// - Byte count is 32 bits; zero means four gigabytes, one byte minimum.
// - Each non-pattern transfer starts with a read request toward the fabric; pattern transfers issue none.
// - PCI/X source read request carries command, address and size.
// - VME source read request carries command and address to VME master.
// - PCI/X source uses the PCI-side block-size field.
// - VME source uses the VME-side block-size field.
// - PCI/X master returns data at completion or queue full.
// - VME master returns data at completion or block size reached.
// - Write requests toward the destination once buffer holds data.
// - PCI/X-to-VME fills and drains the buffer concurrently.
// - VME-to-PCI/X fills and drains the buffer concurrently.
// - PCI/X-to-PCI/X fills buffer to a level, then drains it.
// - VME-to-VME fills buffer to a level, then drains it.
// - VME-to-VME reads alternate between two VME read command queues.
// - Pattern writes any length to either space, any start address.
// - Pattern starts at software value, static or incrementing.
// - Pattern width is 8 or 32 bits.
// - 32-bit patterns to PCI/X are not byte swapped.
// - Only the last 32-bit pattern is shortened to the exact count.
// - Shortened pattern to PCI/X drops bytes from the most significant end.
// - Shortened pattern to VME drops bytes from the least significant end.
// - One 8 Kbyte staging buffer serves every direction.
// - Block sizes 32 to 4096 bytes; back-off 0 to 127 us per block.
`timescale 1ns/100ps
module dmadm_channel #(
    parameter int BUF_DEPTH = dmadm_pkg::BUF_BYTES,
    parameter int FILL_LEVEL = 4096,
    parameter int US_CYCLES = dmadm_pkg::US_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic rd_req_out,
    input wire logic rd_grant_in,
    output logic rd_bus_vme_out,
    output logic rd_queue_out,
    output logic [31:0] rd_addr_out,
    output logic [dmadm_pkg::BLK_W-1:0] rd_size_out,
    input wire logic src_valid_in,
    input wire logic [7:0] src_data_in,
    output logic src_ready_out,
    output logic wr_req_out,
    input wire logic wr_grant_in,
    output logic wr_bus_vme_out,
    output logic [31:0] wr_addr_out,
    output logic [dmadm_pkg::BLK_W-1:0] wr_size_out,
    output logic dst_valid_out,
    output logic [7:0] dst_data_out,
    input wire logic dst_ready_in,
    output logic busy_out
);
    import dmadm_pkg::*;

    localparam int PTR_W = $clog2(BUF_DEPTH);
    localparam int LVL_W = PTR_W + 1;
    localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(BUF_DEPTH);
    localparam logic [LVL_W-1:0] FILL_L = LVL_W'(FILL_LEVEL);

    // Reset release through two flops.
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    logic [31:0] ctrl_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [31:0] count_q;
    logic [31:0] throt_q;
    logic run_q;
    logic fill_q;
    logic [CNT_W:0] rd_left_q;
    logic [CNT_W:0] wr_left_q;
    logic [31:0] rd_addr_q;
    logic [31:0] wr_addr_q;
    logic [BLK_W-1:0] rd_pend_q;
    logic [BLK_W-1:0] wr_pend_q;
    logic [BLK_W-1:0] rd_size_q;
    logic [BLK_W-1:0] wr_size_q;
    logic rd_queue_q;
    logic [BO_TMR_W-1:0] rd_tmr_q;
    logic [BO_TMR_W-1:0] wr_tmr_q;
    logic [31:0] pat_q;
    logic [1:0] pat_idx_q;
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] rptr_q;
    logic [LVL_W-1:0] level_q;
    logic [7:0] dst_data_q;
    logic [31:0] reg_rdata_q;
    logic [7:0] buf_mem [BUF_DEPTH];
    dmadm_rd_state_t rd_st_q;
    dmadm_rd_state_t rd_st_d;
    dmadm_wr_state_t wr_st_q;
    dmadm_wr_state_t wr_st_d;

    // Register decode.
    wire wr_ctrl = reg_wr_in && reg_addr_in == REG_CTRL;
    wire go = wr_ctrl && reg_wdata_in[CTL_GO] && !run_q;
    wire pat_en = ctrl_q[CTL_PAT_EN];
    wire src_vme = ctrl_q[CTL_SRC_VME];
    wire dst_vme = ctrl_q[CTL_DST_VME];
    wire pat_w32 = ctrl_q[CTL_PAT_W32];
    wire pat_inc = ctrl_q[CTL_PAT_INC];
    wire same_bus = !pat_en && (src_vme == dst_vme);

    // Count of zero stands for the full four gigabytes.
    wire [CNT_W:0] total = (count_q == 32'h0000_0000) ?
        {1'b1, 32'h0000_0000} : {1'b0, count_q};

    // Block sizes are 32 bytes shifted by a 3-bit code.
    wire [BS_W-1:0] pbs_code = ctrl_q[CTL_PBS_LSB +: BS_W];
    wire [BS_W-1:0] vbs_code = ctrl_q[CTL_VBS_LSB +: BS_W];
    wire [BLK_W-1:0] pbs_bytes = BLK_MIN << pbs_code;
    wire [BLK_W-1:0] vbs_bytes = BLK_MIN << vbs_code;
    wire [BLK_W-1:0] src_blk = src_vme ? vbs_bytes : pbs_bytes;
    wire [BLK_W-1:0] dst_blk = dst_vme ? vbs_bytes : pbs_bytes;
    wire [BO_W-1:0] pbo_us = throt_q[THR_PBO_LSB +: BO_W];
    wire [BO_W-1:0] vbo_us = throt_q[THR_VBO_LSB +: BO_W];
    wire [BO_W-1:0] src_bo = src_vme ? vbo_us : pbo_us;
    wire [BO_W-1:0] dst_bo = dst_vme ? vbo_us : pbo_us;
    wire [BO_TMR_W-1:0] src_bo_cyc =
        BO_TMR_W'(src_bo) * BO_TMR_W'(US_CYCLES);
    wire [BO_TMR_W-1:0] dst_bo_cyc =
        BO_TMR_W'(dst_bo) * BO_TMR_W'(US_CYCLES);

    // Read request sizing against free buffer space, pending bytes reserved.
    wire [BLK_W-1:0] rd_sz = (rd_left_q < {{(CNT_W+1-BLK_W){1'b0}}, src_blk})
        ? rd_left_q[BLK_W-1:0] : src_blk;
    wire [LVL_W-1:0] free = DEPTH_L - level_q - LVL_W'(rd_pend_q);
    wire rd_allow = !same_bus || fill_q;
    wire wr_allow = !same_bus || !fill_q;
    wire rd_start = run_q && !pat_en && rd_allow &&
        rd_left_q != '0 && free >= LVL_W'(rd_sz);

    // Write sizing: what is buffered, capped by the destination block.
    wire [BLK_W-1:0] wr_sz = (level_q < LVL_W'(dst_blk))
        ? level_q[BLK_W-1:0] : dst_blk;
    wire wr_start = run_q && wr_allow && level_q != '0 &&
        wr_left_q != '0;

    // Buffer traffic.
    wire src_acc = rd_st_q == DMADM_RD_DATA && src_valid_in;
    wire pat_push = run_q && pat_en && rd_left_q != '0 && level_q < DEPTH_L;
    wire pop = wr_st_q == DMADM_WR_DATA && dst_ready_in;
    wire push = src_acc || pat_push;

    // Pattern byte: PCI/X takes low byte first, VME high byte first, so a
    // short count drops from the opposite end for each space.
    wire [1:0] pat_sel = dst_vme ? ~pat_idx_q : pat_idx_q;
    wire [31:0] pat_sh = pat_q >> {pat_sel, 3'b000};
    wire [7:0] pat_byte = pat_w32 ? pat_sh[7:0] : pat_q[7:0];
    wire [7:0] push_data = pat_en ? pat_byte : src_data_in;
    wire pat_step = pat_w32 ? (pat_idx_q == 2'b11) : 1'b1;

    wire [PTR_W-1:0] rptr_d = rptr_q + PTR_W'(pop);
    wire last_wr = pop && wr_left_q == {{CNT_W{1'b0}}, 1'b1};

    always_comb begin
        rd_st_d = rd_st_q;
        unique case (rd_st_q)
            DMADM_RD_IDLE: begin
                if (rd_start) begin
                    rd_st_d = DMADM_RD_REQ;
                end
            end
            DMADM_RD_REQ: begin
                if (rd_grant_in) begin
                    rd_st_d = DMADM_RD_DATA;
                end
            end
            DMADM_RD_DATA: begin
                // The source master decides when data comes back.
                if (src_valid_in && rd_pend_q == 13'h0001) begin
                    rd_st_d = DMADM_RD_WAIT;
                end
            end
            DMADM_RD_WAIT: begin
                if (rd_tmr_q == '0) begin
                    rd_st_d = DMADM_RD_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        wr_st_d = wr_st_q;
        unique case (wr_st_q)
            DMADM_WR_IDLE: begin
                if (wr_start) begin
                    wr_st_d = DMADM_WR_REQ;
                end
            end
            DMADM_WR_REQ: begin
                if (wr_grant_in) begin
                    wr_st_d = DMADM_WR_DATA;
                end
            end
            DMADM_WR_DATA: begin
                if (pop && wr_pend_q == 13'h0001) begin
                    wr_st_d = DMADM_WR_WAIT;
                end
            end
            DMADM_WR_WAIT: begin
                if (wr_tmr_q == '0) begin
                    wr_st_d = DMADM_WR_IDLE;
                end
            end
        endcase
    end

    // Configuration registers; changing them mid-transfer is not guarded.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            count_q <= 32'h0000_0000;
            throt_q <= THROT_RST;
        end else if (reg_wr_in) begin
            if (reg_addr_in == REG_CTRL) begin
                ctrl_q <= reg_wdata_in & ~(32'h0000_0001 << CTL_GO);
            end
            if (reg_addr_in == REG_SRC) begin
                src_q <= reg_wdata_in;
            end
            if (reg_addr_in == REG_DST) begin
                dst_q <= reg_wdata_in;
            end
            if (reg_addr_in == REG_COUNT) begin
                count_q <= reg_wdata_in;
            end
            if (reg_addr_in == REG_THROT) begin
                throt_q <= reg_wdata_in;
            end
        end
    end

    // Launch and completion. The go write samples the other fields as
    // they stand before that write, so they are set up beforehand.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            fill_q <= 1'b1;
        end else if (go) begin
            run_q <= 1'b1;
            fill_q <= 1'b1;
        end else begin
            if (last_wr) begin
                run_q <= 1'b0;
            end
            if (same_bus && fill_q && (level_q >= FILL_L ||
                (rd_left_q == '0 && rd_st_q != DMADM_RD_DATA))) begin
                fill_q <= 1'b0;
            end else if (same_bus && !fill_q && level_q == '0 &&
                wr_st_q == DMADM_WR_IDLE) begin
                fill_q <= 1'b1;
            end
        end
    end

    // Read side bookkeeping.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_st_q <= DMADM_RD_IDLE;
            rd_left_q <= '0;
            rd_addr_q <= 32'h0000_0000;
            rd_pend_q <= '0;
            rd_size_q <= '0;
            rd_queue_q <= 1'b0;
            rd_tmr_q <= '0;
        end else begin
            rd_st_q <= rd_st_d;
            if (go) begin
                rd_left_q <= total;
                rd_addr_q <= src_q;
                rd_queue_q <= 1'b0;
            end else if (pat_push) begin
                rd_left_q <= rd_left_q - 33'h0_0000_0001;
            end
            if (rd_st_q == DMADM_RD_IDLE && rd_start) begin
                rd_size_q <= rd_sz;
            end
            if (rd_st_q == DMADM_RD_REQ && rd_grant_in) begin
                rd_pend_q <= rd_size_q;
                rd_addr_q <= rd_addr_q + 32'(rd_size_q);
                rd_left_q <= rd_left_q - 33'(rd_size_q);
                if (src_vme && dst_vme) begin
                    rd_queue_q <= ~rd_queue_q;
                end
            end
            if (src_acc) begin
                rd_pend_q <= rd_pend_q - 13'h0001;
            end
            if (rd_st_q == DMADM_RD_DATA && rd_st_d == DMADM_RD_WAIT) begin
                rd_tmr_q <= src_bo_cyc;
            end else if (rd_st_q == DMADM_RD_WAIT && rd_tmr_q != '0) begin
                rd_tmr_q <= rd_tmr_q - 24'h00_0001;
            end
        end
    end

    // Write side bookkeeping.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_st_q <= DMADM_WR_IDLE;
            wr_left_q <= '0;
            wr_addr_q <= 32'h0000_0000;
            wr_pend_q <= '0;
            wr_size_q <= '0;
            wr_tmr_q <= '0;
        end else begin
            wr_st_q <= wr_st_d;
            if (go) begin
                wr_left_q <= total;
                wr_addr_q <= dst_q;
            end else if (pop) begin
                wr_left_q <= wr_left_q - 33'h0_0000_0001;
            end
            if (wr_st_q == DMADM_WR_IDLE && wr_start) begin
                wr_size_q <= wr_sz;
            end
            if (wr_st_q == DMADM_WR_REQ && wr_grant_in) begin
                wr_pend_q <= wr_size_q;
                wr_addr_q <= wr_addr_q + 32'(wr_size_q);
            end
            if (pop) begin
                wr_pend_q <= wr_pend_q - 13'h0001;
            end
            if (wr_st_q == DMADM_WR_DATA && wr_st_d == DMADM_WR_WAIT) begin
                wr_tmr_q <= dst_bo_cyc;
            end else if (wr_st_q == DMADM_WR_WAIT && wr_tmr_q != '0) begin
                wr_tmr_q <= wr_tmr_q - 24'h00_0001;
            end
        end
    end

    // Pattern generator state.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pat_q <= 32'h0000_0000;
            pat_idx_q <= 2'b00;
        end else if (go) begin
            pat_q <= src_q;
            pat_idx_q <= 2'b00;
        end else if (pat_push) begin
            pat_idx_q <= pat_w32 ? pat_idx_q + 2'b01 : 2'b00;
            if (pat_inc && pat_step) begin
                pat_q <= pat_w32 ? pat_q + 32'h0000_0001 :
                    {24'h00_0000, pat_q[7:0] + 8'h01};
            end
        end
    end

    // Staging buffer pointers and level.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
            level_q <= '0;
        end else if (go) begin
            wptr_q <= '0;
            rptr_q <= '0;
            level_q <= '0;
        end else begin
            wptr_q <= wptr_q + PTR_W'(push);
            rptr_q <= rptr_d;
            level_q <= level_q + LVL_W'(push) - LVL_W'(pop);
        end
    end

    // Buffer array has no reset; data is only read after being written.
    always_ff @(posedge clock_in) begin
        if (push) begin
            buf_mem[wptr_q] <= push_data;
        end
    end

    // Output byte register looks one entry ahead, with a bypass for a
    // byte that lands in the slot being fetched.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            dst_data_q <= 8'h00;
        end else if (push && wptr_q == rptr_d) begin
            dst_data_q <= push_data;
        end else begin
            dst_data_q <= buf_mem[rptr_d];
        end
    end

    // Register read data, one cycle after the read strobe.
    wire [31:0] status_w = (32'(level_q) << STA_LVL_LSB) |
        (32'(fill_q) << STA_FILL) | (32'(run_q) << STA_BUSY);
    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr_in)
            REG_CTRL: rd_mux = ctrl_q;
            REG_SRC: rd_mux = src_q;
            REG_DST: rd_mux = dst_q;
            REG_COUNT: rd_mux = count_q;
            REG_THROT: rd_mux = throt_q;
            REG_STATUS: rd_mux = status_w;
            REG_REMAIN: rd_mux = wr_left_q[31:0];
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata_out = reg_rdata_q;
    assign rd_req_out = rd_st_q == DMADM_RD_REQ;
    assign rd_bus_vme_out = src_vme;
    assign rd_queue_out = rd_queue_q;
    assign rd_addr_out = rd_addr_q;
    assign rd_size_out = rd_size_q;
    assign src_ready_out = rd_st_q == DMADM_RD_DATA;
    assign wr_req_out = wr_st_q == DMADM_WR_REQ;
    assign wr_bus_vme_out = dst_vme;
    assign wr_addr_out = wr_addr_q;
    assign wr_size_out = wr_size_q;
    assign dst_valid_out = wr_st_q == DMADM_WR_DATA;
    assign dst_data_out = dst_data_q;
    assign busy_out = run_q;
endmodule

/* dmadm_channel_sva.sv */
`timescale 1ns/100ps
module dmadm_channel_chk (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic rd_req_out,
    input wire logic rd_grant_in,
    input wire logic rd_bus_vme_out,
    input wire logic rd_queue_out,
    input wire logic [31:0] rd_addr_out,
    input wire logic [dmadm_pkg::BLK_W-1:0] rd_size_out,
    input wire logic src_ready_out,
    input wire logic wr_req_out,
    input wire logic wr_grant_in,
    input wire logic wr_bus_vme_out,
    input wire logic [31:0] wr_addr_out,
    input wire logic [dmadm_pkg::BLK_W-1:0] wr_size_out,
    input wire logic dst_valid_out,
    input wire logic [7:0] dst_data_out,
    input wire logic dst_ready_in,
    input wire logic busy_out
);
    import dmadm_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    wire go_wr = reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[CTL_GO];
    AST_RDATA_ZERO: assert property (!$past(reg_rd_in) |->
        reg_rdata_out == 32'h0) else $error("read data outside slot");
    AST_GO_BUSY: assert property (go_wr && !busy_out |-> ##[1:2] busy_out)
        else $error("go did not start the channel");
    AST_GO_READ: assert property (go_wr && !busy_out &&
        !reg_wdata_in[CTL_PAT_EN] |-> ##[1:4] rd_req_out)
        else $error("no read request after go");
    AST_RD_HOLD: assert property (rd_req_out && !rd_grant_in |=>
        rd_req_out && $stable(rd_addr_out) && $stable(rd_size_out))
        else $error("read request changed before grant");
    AST_RD_SIZE: assert property (rd_req_out |-> rd_size_out != 13'h0 &&
        rd_size_out <= 13'h1000) else $error("read size out of range");
    AST_WR_HOLD: assert property (wr_req_out && !wr_grant_in |=>
        wr_req_out && $stable(wr_addr_out) && $stable(wr_size_out))
        else $error("write request changed before grant");
    AST_DST_HOLD: assert property (dst_valid_out && !dst_ready_in |=>
        dst_valid_out && $stable(dst_data_out))
        else $error("destination byte dropped while stalled");
    AST_Q_TOGGLE: assert property (rd_req_out && rd_grant_in &&
        rd_bus_vme_out && wr_bus_vme_out |=> rd_queue_out != $past(rd_queue_out))
        else $error("read queue did not alternate");
    AST_SAME_BUS: assert property (rd_bus_vme_out == wr_bus_vme_out |->
        !(src_ready_out && dst_valid_out)) else $error("same bus overlap");
    AST_IDLE_QUIET: assert property (!busy_out |->
        !rd_req_out && !wr_req_out && !dst_valid_out)
        else $error("traffic while idle");
endmodule
bind dmadm_channel dmadm_channel_chk dmadm_channel_chk_inst (.clock_in,
    .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .rd_req_out, .rd_grant_in, .rd_bus_vme_out, .rd_queue_out,
    .rd_addr_out, .rd_size_out, .src_ready_out, .wr_req_out, .wr_grant_in,
    .wr_bus_vme_out, .wr_addr_out, .wr_size_out, .dst_valid_out,
    .dst_data_out, .dst_ready_in, .busy_out);

/* dmadm_fabric_model.sv */
`timescale 1ns/100ps
module dmadm_fabric_model (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic slow_in,
    input wire logic rd_req_in,
    input wire logic [31:0] rd_addr_in,
    input wire logic src_ready_in,
    input wire logic wr_req_in,
    output logic rd_grant_out,
    output logic src_valid_out,
    output logic [7:0] src_data_out,
    output logic wr_grant_out,
    output logic dst_ready_out
);
    logic [31:0] ptr_q;
    logic [1:0] cnt_q;
    // Slow mode answers one cycle in four to stretch every handshake.
    wire go = !slow_in || cnt_q == 2'h3;
    wire [7:0] byte_v = ptr_q[7:0] ^ 8'hA5;
    // An idle data line shows the inverse so a stale byte never passes.
    assign src_data_out = src_valid_out ? byte_v : ~byte_v;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {ptr_q, cnt_q, rd_grant_out, wr_grant_out} <= '0;
            {src_valid_out, dst_ready_out} <= '0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            rd_grant_out <= rd_req_in && !rd_grant_out && go;
            wr_grant_out <= wr_req_in && !wr_grant_out && go;
            if (rd_req_in && rd_grant_out) begin
                ptr_q <= rd_addr_in;
            end else if (src_valid_out && src_ready_in) begin
                ptr_q <= ptr_q + 32'h1;
            end
            src_valid_out <= src_ready_in && go;
            dst_ready_out <= go;
        end
    end
endmodule

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
    import dmadm_pkg::*;
    logic clock_in, reset_n_in, reg_wr_in, reg_rd_in, slow;
    logic rp = 1'b0;
    logic [31:0] v, na = 32'h0000_0000, nw = 32'h0000_0000;
    logic rd_grant_in, src_valid_in, wr_grant_in, dst_ready_in;
    logic rd_req_out, rd_bus_vme_out, rd_queue_out, src_ready_out;
    logic wr_req_out, wr_bus_vme_out, dst_valid_out, busy_out;
    logic [7:0] reg_addr_in, src_data_in, dst_data_out;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd_addr_out, wr_addr_out;
    logic [BLK_W-1:0] rd_size_out, wr_size_out;
    logic [31:0] rq[$];
    logic [7:0] dq[$];
    int error_cnt = 0;
    int checks_done = 0;
    dmadm_channel #(.FILL_LEVEL(64), .US_CYCLES(2)) dmadm_channel_inst (.*);
    dmadm_fabric_model dmadm_fabric_model_inst (.clock_in, .reset_n_in,
        .slow_in(slow), .rd_req_in(rd_req_out), .rd_addr_in(rd_addr_out),
        .src_ready_in(src_ready_out), .wr_req_in(wr_req_out),
        .rd_grant_out(rd_grant_in), .src_valid_out(src_valid_in),
        .src_data_out(src_data_in), .wr_grant_out(wr_grant_in),
        .dst_ready_out(dst_ready_in));
    always #2 clock_in = ~clock_in;
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: word %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Strobes stay up between calls so back-to-back cycles need no gap.
    task automatic rw(input logic [7:0] a, input logic [31:0] d, input bit r);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= !r;
        reg_rd_in <= r;
        if (r) rq.push_back(d);
        @(posedge clock_in);
    endtask
    task automatic rel;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(posedge clock_in);
    endtask
    // Addresses must advance by exactly the bytes moved since the launch.
    always @(posedge clock_in) begin
        if (rp) chk32(reg_rdata_out, rq.pop_front());
        rp <= reg_rd_in;
        if (rd_req_out && rd_grant_in)
            chk32(rd_addr_out, v + na);
        if (wr_req_out && wr_grant_in)
            chk32(wr_addr_out, ~v + nw);
        na <= busy_out ? na + 32'(src_valid_in && src_ready_out) : 32'h0;
        nw <= busy_out ? nw + 32'(dst_valid_out && dst_ready_in) : 32'h0;
        if (dst_valid_out && dst_ready_in) begin
            chk32(32'(dq.size() == 0), 32'h0);
            chk8(dst_data_out,
                dq.size() ? dq.pop_front() : 8'h00);
        end
    end
    initial begin
        repeat (30000) @(posedge clock_in);
        chk32(32'h1, 32'h0);
        test_done;
    end
    initial begin
        int i, k, n, cnt;
        logic [15:0] s;
        logic [31:0] w, ctrl;
        bit pat;
        {clock_in, reset_n_in, reg_wr_in, reg_rd_in, slow} = '0;
        reg_addr_in = 8'h0;
        reg_wdata_in = 32'h0;
        s = 16'h0B9A;
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rw(REG_CTRL, CTRL_RST, 1);
        rw(REG_THROT, THROT_RST, 1);
        rw(8'h1C, 32'h0, 1);
        for (i = 0; i < 8; i++) begin
            s = lf(s);
            v = {s, lf(s)};
            pat = i < 4;
            ctrl = 32'h0;
            ctrl[CTL_PAT_EN] = pat;
            ctrl[CTL_VBS_LSB] = 1'b1;
            ctrl[CTL_DST_VME] = pat ? i[0] : i[1];
            ctrl[CTL_SRC_VME] = !pat && i[0];
            ctrl[CTL_PAT_W32] = pat && i[1];
            ctrl[CTL_PAT_INC] = pat && !i[0];
            cnt = pat ? 7 : 70;
            for (k = 0; k < cnt; k++) begin
                w = v + (ctrl[CTL_PAT_INC] ? k / 4 : 0);
                n = ctrl[CTL_DST_VME] ? 3 - k % 4 : k % 4;
                if (!pat) dq.push_back((v[7:0] + k[7:0]) ^ 8'hA5);
                else if (!ctrl[CTL_PAT_W32])
                    dq.push_back(v[7:0] + (ctrl[CTL_PAT_INC] ? k[7:0] : 8'h0));
                else dq.push_back(w[8 * n +: 8]);
            end
            slow <= i[0];
            rw(REG_SRC, v, 0);
            rw(REG_DST, ~v, 0);
            rw(REG_COUNT, cnt, 0);
            rw(REG_THROT, 32'h0000_0101, 0);
            rw(REG_CTRL, ctrl, 0);
            rw(REG_CTRL, ctrl | 32'h1, 0);
            rel;
            n = 0;
            repeat (3) @(posedge clock_in);
            while (busy_out !== 1'b0 && n < 9000) begin
                @(posedge clock_in);
                n++;
            end
            rw(REG_REMAIN, 32'h0, 1);
            rw(REG_CTRL, ctrl, 1);
            rw(REG_SRC, v, 1);
            rel;
            repeat (2) @(posedge clock_in);
            chk32(32'(busy_out), 32'h0);
            chk32(32'(dq.size()), 32'h0);
        end
        test_done;
    end
endmodule
